//--- rtl/asss_pkg.sv
package asss_pkg;

  // ----------------------------------------------------------------
  // Clock and rate figures
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int MIN_RATE_HZ = 28_000;
  localparam int MAX_RATE_HZ = 200_000;
  localparam int SPLIT_LO_HZ = 88_200;
  localparam int SPLIT_HI_HZ = 96_000;
  localparam int PERIOD_W = 12;

  // Shortest period rounds up, longest rounds down
  localparam int MIN_PERIOD_CYC = (SYS_CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
  localparam int MAX_PERIOD_CYC = SYS_CLK_HZ / MIN_RATE_HZ;
  localparam int SPLIT_MIN_CYC = SYS_CLK_HZ / SPLIT_HI_HZ;
  localparam int SPLIT_MAX_CYC = (SYS_CLK_HZ + SPLIT_LO_HZ - 1) / SPLIT_LO_HZ;

  localparam logic [PERIOD_W-1:0] MIN_PERIOD = PERIOD_W'(MIN_PERIOD_CYC);
  localparam logic [PERIOD_W-1:0] MAX_PERIOD = PERIOD_W'(MAX_PERIOD_CYC);
  localparam logic [PERIOD_W-1:0] SPLIT_MIN = PERIOD_W'(SPLIT_MIN_CYC);
  localparam logic [PERIOD_W-1:0] SPLIT_MAX = PERIOD_W'(SPLIT_MAX_CYC);
  localparam logic [PERIOD_W-1:0] JITTER_TOL = 12'h004;
  localparam logic [PERIOD_W-1:0] MATCH_TOL = 12'h008;
  localparam logic [PERIOD_W-1:0] RATE_RESET = 12'h412;

  // ----------------------------------------------------------------
  // Sources and per-input states
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 3;
  localparam logic [1:0] SRC_WORD = 2'h0;
  localparam logic [1:0] SRC_OPT = 2'h1;
  localparam logic [1:0] SRC_SPDIF = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h3;
  localparam logic [1:0] LS_NONE = 2'h0;
  localparam logic [1:0] LS_LOCK = 2'h1;
  localparam logic [1:0] LS_SYNC = 2'h2;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_REF_PER = 8'h0c;
  localparam logic [7:0] OFS_PER_BASE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_PREF_LSB = 1;
  localparam int STAT_REF_LSB = 0;
  localparam int STAT_SLAVE_BIT = 2;
  localparam int STAT_SPLIT_BIT = 3;
  localparam int STAT_LOCK_LSB = 8;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic [1:0] CTRL_PREF_RST = SRC_NONE;
  localparam int IRQ_W = 5;
  localparam int IRQ_REF_CHG = 0;
  localparam int IRQ_LOCK_LSB = 1;
  localparam int IRQ_MASTER_FB = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASSS_ST_MASTER = 2'b00,
    ASSS_ST_SLAVE = 2'b01
  } asss_clk_state_t;

  typedef struct packed {
    logic locked;
    logic [PERIOD_W-1:0] period;
  } asss_meter_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } asss_ahb_req_t;

  function automatic logic asss_near(input logic [PERIOD_W-1:0] a,
                                     input logic [PERIOD_W-1:0] b,
                                     input logic [PERIOD_W-1:0] tol);
    logic [PERIOD_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= tol;
  endfunction

endpackage

//--- rtl/asss_rate_meter.sv
`timescale 1ns/1ps

module asss_rate_meter #(
  parameter int LOCK_COUNT = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link clock pin
  input wire logic link_clk_in,
  // Measurement
  output asss_pkg::asss_meter_t meter_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [asss_pkg::PERIOD_W-1:0] cnt;
    logic [asss_pkg::PERIOD_W-1:0] period;
    logic [3:0] stable;
    logic locked;
  } asss_meter_st_t;

  asss_meter_st_t st_reg;
  asss_meter_st_t st_next;
  logic rise;

  initial begin
    if (LOCK_COUNT < 1 || LOCK_COUNT > 15) begin
      $error("LOCK_COUNT must lie in 1..15");
    end
  end

  // ----------------------------------------------------------------
  // Period measurement
  // ----------------------------------------------------------------

  // Edge found only behind the second sync stage
  assign rise = st_reg.s2 & ~st_reg.prev;

  // Count sys clocks between rising edges; steady in-range period locks
  always_comb begin
    st_next = st_reg;
    st_next.s1 = link_clk_in;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    if (rise) begin
      st_next.cnt = 12'h001;
      if (st_reg.cnt >= asss_pkg::MIN_PERIOD && st_reg.cnt <= asss_pkg::MAX_PERIOD) begin
        if (asss_pkg::asss_near(st_reg.cnt, st_reg.period, asss_pkg::JITTER_TOL)) begin
          if (st_reg.stable != 4'(LOCK_COUNT)) begin
            st_next.stable = st_reg.stable + 4'h1;
          end
        end else begin
          st_next.stable = 4'h0;
        end
        st_next.period = st_reg.cnt;
      end else begin
        st_next.stable = 4'h0;
        st_next.period = '0;
      end
    end else if (st_reg.cnt > asss_pkg::MAX_PERIOD) begin
      // Saturated: edges stopped, signal gone
      st_next.stable = 4'h0;
      st_next.period = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 12'h001;
    end
    st_next.locked = (st_next.stable == 4'(LOCK_COUNT));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign meter_out = '{locked: st_reg.locked, period: st_reg.period};

endmodule // asss_rate_meter

//--- rtl/asss_selector.sv
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - Auto mode watches every input for signal
// - Matching input becomes clock; indicator shows slave
// - Optical and coax inputs coexist; one clocks
// - Without preference, first valid input wins
// - Preferred input used while valid; else scan
// - No valid input falls back to master
// - Report active reference and its period
// - Per input: none, locked, or sync
// - Lock anywhere from 28 to 200 kHz
// - Word clock accepts 28 to 200 kHz
// - Optical preferred at 88.2/96 enters split
// - Split: optical link stays at single rate
// - Split: optical period reads double system
// - Master: rate request applies at once
// - Candidates are word, optical, coax
module asss_selector #(
  parameter int LOCK_COUNT = 4
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // Link clock pins
  input wire logic WORD_CLK_IN,
  input wire logic OPT_FRAME_IN,
  input wire logic SPDIF_FRAME_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Clock status
  output logic [1:0] REF_SEL_OUT,
  output logic SLAVE_OUT,
  output logic SPLIT_OUT,
  output logic [5:0] LOCK_STATE_OUT,
  output logic [11:0] SYS_PERIOD_OUT,
  // Interrupt
  output logic IRQ_OUT
);

  localparam int PW = asss_pkg::PERIOD_W;

  typedef struct packed {
    asss_pkg::asss_ahb_req_t req;
    logic [31:0] hrdata;
    logic hreadyout;
    logic auto_mode;
    logic [1:0] pref;
    logic [PW-1:0] rate_period;
    logic [asss_pkg::IRQ_W-1:0] irq_mask;
    logic [asss_pkg::IRQ_W-1:0] irq_stat;
    logic irq;
    asss_pkg::asss_clk_state_t state;
    logic [1:0] active_ref;
    logic split;
    logic [2*asss_pkg::NUM_SRC-1:0] lock_state;
    logic [PW-1:0] sys_period;
  } asss_sel_st_t;

  asss_sel_st_t st_reg;
  asss_sel_st_t st_next;
  asss_pkg::asss_meter_t meter [asss_pkg::NUM_SRC];
  logic [asss_pkg::NUM_SRC-1:0] link_clk;

  initial begin
    if (asss_pkg::MAX_PERIOD_CYC >= (1 << PW) / 2) begin
      $error("Period width too small for doubled optical period");
    end
  end

  // ----------------------------------------------------------------
  // Per-input meters
  // ----------------------------------------------------------------

  // All three candidates measured side by side, no input selector
  assign link_clk[asss_pkg::SRC_WORD] = WORD_CLK_IN;
  assign link_clk[asss_pkg::SRC_OPT] = OPT_FRAME_IN;
  assign link_clk[asss_pkg::SRC_SPDIF] = SPDIF_FRAME_IN;

  for (genvar g = 0; g < asss_pkg::NUM_SRC; g++) begin : g_meter
    asss_rate_meter #(
      .LOCK_COUNT(LOCK_COUNT)
    ) u_meter (
      .clk_in(CLK_SYS_IN),
      .rst_in(RST_IN),
      .link_clk_in(link_clk[g]),
      .meter_out(meter[g])
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Register access, source choice, status and events in one pass
  always_comb begin
    logic [31:0] rd;
    logic [asss_pkg::IRQ_W-1:0] clr;
    logic [asss_pkg::IRQ_W-1:0] ev;
    logic [asss_pkg::NUM_SRC-1:0] cand;
    logic [PW-1:0] target;
    logic [PW-1:0] sys_target;
    logic found;
    logic [1:0] pick;
    logic [1:0] start;
    logic [1:0] idx;
    logic split;
    int j;
    rd = '0;
    clr = '0;
    ev = '0;
    cand = '0;
    target = '0;
    sys_target = '0;
    found = 1'b0;
    pick = asss_pkg::SRC_NONE;
    start = 2'h0;
    idx = 2'h0;
    split = 1'b0;
    j = 0;
    st_next = st_reg;

    // Zero-wait slave: data phase always completes at once
    st_next.hreadyout = 1'b1;
    st_next.hrdata = '0;

    // Write data phase
    if (st_reg.req.valid && st_reg.req.write) begin
      case (st_reg.req.addr)
        asss_pkg::OFS_CTRL: begin
          st_next.auto_mode = HWDATA_IN[asss_pkg::CTRL_AUTO_BIT];
          st_next.pref = HWDATA_IN[asss_pkg::CTRL_PREF_LSB +: 2];
        end
        asss_pkg::OFS_RATE: begin
          st_next.rate_period = HWDATA_IN[PW-1:0];
        end
        asss_pkg::OFS_IRQ_STAT: begin
          clr = HWDATA_IN[asss_pkg::IRQ_W-1:0];
        end
        asss_pkg::OFS_IRQ_MASK: begin
          st_next.irq_mask = HWDATA_IN[asss_pkg::IRQ_W-1:0];
        end
        default: begin
          // Read-only or unmapped: write dropped, still OKAY
        end
      endcase
    end

    // Address phase capture; read data prepared for the data phase
    st_next.req.valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    st_next.req.write = HWRITE_IN;
    st_next.req.addr = HADDR_IN[7:0];
    if (st_next.req.valid && !HWRITE_IN) begin
      case (HADDR_IN[7:0])
        asss_pkg::OFS_CTRL: begin
          rd[asss_pkg::CTRL_AUTO_BIT] = st_reg.auto_mode;
          rd[asss_pkg::CTRL_PREF_LSB +: 2] = st_reg.pref;
        end
        asss_pkg::OFS_RATE: rd[PW-1:0] = st_reg.rate_period;
        asss_pkg::OFS_STATUS: begin
          rd[asss_pkg::STAT_REF_LSB +: 2] = st_reg.active_ref;
          rd[asss_pkg::STAT_SLAVE_BIT] = (st_reg.state == asss_pkg::ASSS_ST_SLAVE);
          rd[asss_pkg::STAT_SPLIT_BIT] = st_reg.split;
          rd[asss_pkg::STAT_LOCK_LSB +: 2*asss_pkg::NUM_SRC] = st_reg.lock_state;
        end
        asss_pkg::OFS_REF_PER: rd[PW-1:0] = st_reg.sys_period;
        asss_pkg::OFS_PER_BASE: rd[PW-1:0] = meter[asss_pkg::SRC_WORD].period;
        asss_pkg::OFS_PER_BASE + 8'h04: rd[PW-1:0] = meter[asss_pkg::SRC_OPT].period;
        asss_pkg::OFS_PER_BASE + 8'h08: rd[PW-1:0] = meter[asss_pkg::SRC_SPDIF].period;
        asss_pkg::OFS_IRQ_STAT: rd[asss_pkg::IRQ_W-1:0] = st_reg.irq_stat;
        asss_pkg::OFS_IRQ_MASK: rd[asss_pkg::IRQ_W-1:0] = st_reg.irq_mask;
        default: rd = '0;
      endcase
      st_next.hrdata = rd;
    end

    // Split when optical preferred at a double-speed playback rate
    split = st_reg.auto_mode && (st_reg.pref == asss_pkg::SRC_OPT) &&
            (st_reg.rate_period >= asss_pkg::SPLIT_MIN) &&
            (st_reg.rate_period <= asss_pkg::SPLIT_MAX);

    // Candidate: locked and matching the playback rate
    for (int i = 0; i < asss_pkg::NUM_SRC; i++) begin
      target = st_reg.rate_period;
      if (split && i == int'(asss_pkg::SRC_OPT)) begin
        target = {st_reg.rate_period[PW-2:0], 1'b0};
      end
      cand[i] = meter[i].locked &&
                asss_pkg::asss_near(meter[i].period, target, asss_pkg::MATCH_TOL);
    end

    // Scan from the preferred input onward; no preference starts at word clock
    start = (st_reg.pref == asss_pkg::SRC_NONE) ? asss_pkg::SRC_WORD : st_reg.pref;
    for (int k = 0; k < asss_pkg::NUM_SRC; k++) begin
      j = (int'(start) + k) % asss_pkg::NUM_SRC;
      idx = 2'(j);
      if (!found && cand[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end

    // Single clock source chosen; manual master ignores every input
    if (!st_reg.auto_mode) begin
      st_next.state = asss_pkg::ASSS_ST_MASTER;
      st_next.active_ref = asss_pkg::SRC_NONE;
    end else begin
      case (st_reg.state)
        asss_pkg::ASSS_ST_MASTER: begin
          if (found) begin
            st_next.state = asss_pkg::ASSS_ST_SLAVE;
            st_next.active_ref = pick;
          end
        end
        asss_pkg::ASSS_ST_SLAVE: begin
          if (found) begin
            st_next.active_ref = pick;
          end else begin
            st_next.state = asss_pkg::ASSS_ST_MASTER;
            st_next.active_ref = asss_pkg::SRC_NONE;
          end
        end
        default: begin
          st_next.state = asss_pkg::ASSS_ST_MASTER;
          st_next.active_ref = asss_pkg::SRC_NONE;
        end
      endcase
    end
    st_next.split = split;

    // System period: request in master (at once), recovered in slave
    if (st_next.state == asss_pkg::ASSS_ST_MASTER) begin
      st_next.sys_period = st_reg.rate_period;
    end else if (st_next.active_ref == asss_pkg::SRC_OPT && split) begin
      st_next.sys_period = {1'b0, meter[asss_pkg::SRC_OPT].period[PW-1:1]};
    end else begin
      st_next.sys_period = meter[st_next.active_ref].period;
    end

    // Per-input status, kept even in manual master
    for (int i = 0; i < asss_pkg::NUM_SRC; i++) begin
      sys_target = st_next.sys_period;
      if (split && i == int'(asss_pkg::SRC_OPT)) begin
        sys_target = {st_next.sys_period[PW-2:0], 1'b0};
      end
      if (!meter[i].locked) begin
        st_next.lock_state[2*i +: 2] = asss_pkg::LS_NONE;
      end else if (asss_pkg::asss_near(meter[i].period, sys_target, asss_pkg::MATCH_TOL)) begin
        st_next.lock_state[2*i +: 2] = asss_pkg::LS_SYNC;
      end else begin
        st_next.lock_state[2*i +: 2] = asss_pkg::LS_LOCK;
      end
      ev[asss_pkg::IRQ_LOCK_LSB + i] = (st_next.lock_state[2*i +: 2] !=
                                        st_reg.lock_state[2*i +: 2]);
    end

    // Events; a set in the clearing cycle survives the clear
    ev[asss_pkg::IRQ_REF_CHG] = (st_next.active_ref != st_reg.active_ref);
    ev[asss_pkg::IRQ_MASTER_FB] = st_reg.auto_mode &&
                                  (st_reg.state == asss_pkg::ASSS_ST_SLAVE) &&
                                  (st_next.state == asss_pkg::ASSS_ST_MASTER);
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset leaves auto mode on with no preference, master clock
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      st_reg <= '0;
      st_reg.hreadyout <= 1'b1;
      st_reg.auto_mode <= asss_pkg::CTRL_AUTO_RST;
      st_reg.pref <= asss_pkg::CTRL_PREF_RST;
      st_reg.rate_period <= asss_pkg::RATE_RESET;
      st_reg.irq_mask <= asss_pkg::IRQ_MASK_RST;
      st_reg.state <= asss_pkg::ASSS_ST_MASTER;
      st_reg.active_ref <= asss_pkg::SRC_NONE;
      st_reg.sys_period <= asss_pkg::RATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all but HRESP_OUT straight from the state register
  // ----------------------------------------------------------------
  assign HRDATA_OUT = st_reg.hrdata;
  assign HREADYOUT_OUT = st_reg.hreadyout;
  assign HRESP_OUT = 1'b0;  // Always OKAY; no error path exists
  assign REF_SEL_OUT = st_reg.active_ref;
  assign SLAVE_OUT = (st_reg.state == asss_pkg::ASSS_ST_SLAVE);
  assign SPLIT_OUT = st_reg.split;
  assign LOCK_STATE_OUT = st_reg.lock_state;
  assign SYS_PERIOD_OUT = st_reg.sys_period;
  assign IRQ_OUT = st_reg.irq;

endmodule // asss_selector

//--- testbench/asss_monitor.sv
`timescale 1ns/1ps

// ----------
// Port checks
// ----------
module asss_monitor #(
  parameter int LOCK_COUNT = 4
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // Word pin and bus
  input wire logic WORD_CLK_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  // Status
  input wire logic [1:0] REF_SEL_OUT,
  input wire logic SLAVE_OUT,
  input wire logic SPLIT_OUT,
  input wire logic [5:0] LOCK_STATE_OUT,
  input wire logic [11:0] SYS_PERIOD_OUT
);
  logic take;
  logic rd_reg;
  logic wr_reg;
  logic chk_reg;
  logic wclk_reg;
  logic [11:0] rate_reg;
  logic [11:0] idle_reg;

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  // Follow reads, and rate writes into their data phase
  assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  always_ff @(posedge CLK_SYS_IN) begin
    rd_reg <= !RST_IN && take && !HWRITE_IN;
    wr_reg <= !RST_IN && take && HWRITE_IN && HADDR_IN[7:0] == asss_pkg::OFS_RATE;
    chk_reg <= wr_reg;
    wclk_reg <= WORD_CLK_IN;
    if (wr_reg)
      rate_reg <= HWDATA_IN[11:0];
  end

  // Cycles since the last word clock rise; saturates so it never wraps
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN || (WORD_CLK_IN && !wclk_reg))
      idle_reg <= 12'h000;
    else if (idle_reg != 12'hfff)
      idle_reg <= idle_reg + 12'h001;
  end

  property p_slave_ref;
    SLAVE_OUT |-> REF_SEL_OUT != asss_pkg::SRC_NONE;
  endproperty
  a_slave_ref: assert property (p_slave_ref)
    else $error("slave flag without reference");

  property p_master_ref;
    !SLAVE_OUT |-> REF_SEL_OUT == asss_pkg::SRC_NONE;
  endproperty
  a_master_ref: assert property (p_master_ref)
    else $error("master flag with a reference");

  // One cycle of slack, though lock loss and reselection land in the same cycle
  property p_ref_locked;
    SLAVE_OUT |-> ##[0:1] (!SLAVE_OUT || LOCK_STATE_OUT[2*REF_SEL_OUT +: 2] != 2'h0);
  endproperty
  a_ref_locked: assert property (p_ref_locked)
    else $error("reference without lock");

  property p_lock_code;
    LOCK_STATE_OUT[1:0] != 2'h3 && LOCK_STATE_OUT[3:2] != 2'h3 && LOCK_STATE_OUT[5:4] != 2'h3;
  endproperty
  a_lock_code: assert property (p_lock_code)
    else $error("undefined lock state");

  property p_bus_ok;
    HREADYOUT_OUT && !HRESP_OUT;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus wait or error response");

  property p_rdata_idle;
    !rd_reg |-> HRDATA_OUT == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside data phase");

  property p_master_rate;
    chk_reg && !SLAVE_OUT |-> ##[0:2] SYS_PERIOD_OUT == rate_reg;
  endproperty
  a_master_rate: assert property (p_master_rate)
    else $error("rate request not applied");

  property p_word_timeout;
    idle_reg > asss_pkg::MAX_PERIOD + 12'h010 |-> LOCK_STATE_OUT[1:0] == asss_pkg::LS_NONE;
  endproperty
  a_word_timeout: assert property (p_word_timeout)
    else $error("word lock kept without edges");

  c_slave: cover property ($rose(SLAVE_OUT));
  c_split: cover property (SPLIT_OUT && SLAVE_OUT);
  c_fall: cover property ($fell(SLAVE_OUT));
endmodule // asss_monitor

bind asss_selector asss_monitor #(.LOCK_COUNT(LOCK_COUNT)) u_mon (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .WORD_CLK_IN(WORD_CLK_IN),
  .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .REF_SEL_OUT(REF_SEL_OUT),
  .SLAVE_OUT(SLAVE_OUT), .SPLIT_OUT(SPLIT_OUT), .LOCK_STATE_OUT(LOCK_STATE_OUT),
  .SYS_PERIOD_OUT(SYS_PERIOD_OUT)
);

//--- testbench/asss_link_model.sv
`timescale 1ns/1ps

// ----------
// Far side: word, optical and coax frame clocks
// ----------
module asss_link_model (
  // Per source enable and half period in ns
  input wire logic [2:0] en_in,
  input wire logic [47:0] half_ns_in,
  // Frame clocks
  output logic [2:0] lclk_out
);
  logic [2:0] lclk;

  assign lclk_out = lclk;

  // Silent sources stand low; odd ns ticks keep edges off the system edge
  for (genvar i = 0; i < 3; i++) begin : g_src
    initial begin
      lclk[i] = 1'b0;
      #(3 + 2 * i);
      forever begin
        if (en_in[i]) begin
          #(half_ns_in[16*i +: 16]);
          lclk[i] = !lclk[i] && en_in[i];
        end else begin
          lclk[i] = 1'b0;
          #2;
        end
      end
    end
  end
endmodule // asss_link_model

//--- testbench/audio_sync_source_selector_tb.sv
`timescale 1ns/1ps

module audio_sync_source_selector_tb;
  // ----------
  // Signals
  // ----------
  localparam logic [15:0] H48 = 16'h28b4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [1:0] ref_sel;
  logic slave;
  logic split;
  logic [5:0] lock;
  logic [11:0] sys_per;
  logic irq;
  logic [2:0] lk_en = 3'h0;
  logic [47:0] lk_half = 48'h0;
  logic [2:0] lclk;
  logic [31:0] rdat;
  int errors = 0;
  int checks = 0;

  // System clock
  initial begin
    forever #10 clk = ~clk;
  end

  // ----------
  // Design and far side
  // ----------
  asss_selector #(.LOCK_COUNT(4)) u_dut (
    .CLK_SYS_IN(clk), .RST_IN(rst),
    .WORD_CLK_IN(lclk[0]), .OPT_FRAME_IN(lclk[1]), .SPDIF_FRAME_IN(lclk[2]),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .REF_SEL_OUT(ref_sel), .SLAVE_OUT(slave), .SPLIT_OUT(split),
    .LOCK_STATE_OUT(lock), .SYS_PERIOD_OUT(sys_per), .IRQ_OUT(irq)
  );
  asss_link_model u_link (.en_in(lk_en), .half_ns_in(lk_half), .lclk_out(lclk));

  // ----------
  // Tasks
  // ----------
  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Measured periods may wander by up to two cycles with edge phase
  task automatic near(input logic [11:0] g, input logic [11:0] e);
    logic [11:0] d;
    checks++;
    d = (g > e) ? g - e : e - g;
    if ((^g) === 1'bx || d > 12'h002) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Next edge with hready sampled high, bounded
  task automatic rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 99) begin
        errors++;
        $display("[ERR] t=%0t got %h exp 1", $time, hready);
        stop_test();
      end
      @(posedge clk);
    end
  endtask

  // Single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rdat & m, e);
  endtask

  task automatic rdn(input logic [7:0] a, input logic [11:0] e);
    bus(1'b0, a, 32'h0);
    near(rdat[11:0], e);
  endtask

  task automatic src(input int i, input logic on, input logic [15:0] h);
    lk_en[i] <= on;
    lk_half[16*i +: 16] <= h;
  endtask

  // Field k of {ref, lock states} reaches e, bounded
  task automatic wait_v(input int k, input logic [1:0] e);
    int n;
    logic [7:0] o;
    n = 0;
    o = {ref_sel, lock};
    while (o[2*k +: 2] !== e) begin
      @(posedge clk);
      o = {ref_sel, lock};
      n++;
      if (n > 30000) begin
        errors++;
        $display("[ERR] t=%0t got %h exp %h", $time, o[2*k +: 2], e);
        stop_test();
      end
    end
    checks++;
  endtask

  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdm(asss_pkg::OFS_CTRL, 32'hffffffff, 32'h7);
    rdm(asss_pkg::OFS_RATE, 32'hffffffff, 32'h412);
    rdm(asss_pkg::OFS_IRQ_MASK, 32'hffffffff, 32'h0);
    rdm(8'h40, 32'hffffffff, 32'h0);
    wr(asss_pkg::OFS_STATUS, 32'hffffffff);
    rdm(asss_pkg::OFS_STATUS, 32'hffffffff, 32'h3);
    // Manual master: rate applies at once, lock still reported
    wr(asss_pkg::OFS_CTRL, 32'h0);
    wr(asss_pkg::OFS_RATE, 32'h3e8);
    cmp({20'h0, sys_per}, 32'h3e8);
    wr(asss_pkg::OFS_RATE, 32'h412);
    src(2, 1'b1, H48);
    wait_v(2, asss_pkg::LS_SYNC);
    cmp({29'h0, slave, ref_sel}, 32'h3);
    // Auto without preference takes the one valid input
    wr(asss_pkg::OFS_CTRL, 32'h7);
    wait_v(3, asss_pkg::SRC_SPDIF);
    cmp({31'h0, slave}, 32'h1);
    near(sys_per, 12'h412);
    rdn(asss_pkg::OFS_REF_PER, 12'h412);
    rdm(asss_pkg::OFS_STATUS, 32'h7, 32'h6);
    // Event bit held but masked, then unmasked and cleared
    cmp({31'h0, irq}, 32'h0);
    wr(asss_pkg::OFS_IRQ_MASK, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    rdm(asss_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    wr(asss_pkg::OFS_IRQ_STAT, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    wr(asss_pkg::OFS_IRQ_MASK, 32'h10);
    // Optical and coax together, one reference, preference and return
    wr(asss_pkg::OFS_CTRL, 32'h5);
    src(1, 1'b1, H48);
    wait_v(1, asss_pkg::LS_SYNC);
    cmp({30'h0, ref_sel}, 32'h2);
    wr(asss_pkg::OFS_CTRL, 32'h3);
    wait_v(3, asss_pkg::SRC_OPT);
    src(0, 1'b1, 16'h2c4c);
    wr(asss_pkg::OFS_CTRL, 32'h1);
    wait_v(0, asss_pkg::LS_LOCK);
    cmp({30'h0, ref_sel}, 32'h1);
    src(0, 1'b1, H48);
    wait_v(3, asss_pkg::SRC_WORD);
    src(0, 1'b0, H48);
    wait_v(3, asss_pkg::SRC_OPT);
    src(0, 1'b1, H48);
    wait_v(3, asss_pkg::SRC_WORD);
    // Word clock at both ends of the rate range, then far too fast
    src(1, 1'b0, H48);
    src(2, 1'b0, H48);
    wr(asss_pkg::OFS_RATE, 32'h0fa);
    wait_v(3, asss_pkg::SRC_NONE);
    src(0, 1'b1, 16'h09c4);
    wait_v(3, asss_pkg::SRC_WORD);
    rdn(asss_pkg::OFS_PER_BASE, 12'h0fa);
    wr(asss_pkg::OFS_RATE, 32'h6f9);
    wait_v(3, asss_pkg::SRC_NONE);
    src(0, 1'b1, 16'h45ba);
    wait_v(3, asss_pkg::SRC_WORD);
    src(0, 1'b1, 16'h0050);
    wait_v(0, asss_pkg::LS_NONE);
    wait_v(3, asss_pkg::SRC_NONE);
    cmp({30'h0, slave, irq}, 32'h1);
    wr(asss_pkg::OFS_IRQ_STAT, 32'h10);
    cmp({31'h0, irq}, 32'h0);
    // Double rate with optical preferred: pair split
    wr(asss_pkg::OFS_RATE, 32'h209);
    wr(asss_pkg::OFS_CTRL, 32'h3);
    cmp({31'h0, split}, 32'h1);
    src(1, 1'b1, H48);
    src(2, 1'b1, 16'h145a);
    wait_v(3, asss_pkg::SRC_OPT);
    near(sys_per, 12'h209);
    rdn(8'h14, 12'h412);
    rdn(8'h18, 12'h209);
    rdm(asss_pkg::OFS_STATUS, 32'hf, 32'hd);
    stop_test();
  end
endmodule // audio_sync_source_selector_tb
